// [dmbo_addr.sv]
`default_nettype none
module dmbo_addr (
  dmbo_xu_if.adr xu
);
  import dmbo_pkg::*;
  always_comb begin
    xu.adr_ea      = xu.adr_ptr;
    xu.adr_ptr_nxt = xu.adr_ptr;
    xu.adr_wr      = 1'b0;
    unique case (xu.adr_mode)
      AM_PLAIN: begin
      end
      AM_POSTINC: begin
        xu.adr_ptr_nxt = xu.adr_ptr + 16'h0001;
        xu.adr_wr      = 1'b1;
      end
      AM_PREDEC: begin
        xu.adr_ptr_nxt = xu.adr_ptr - 16'h0001;
        xu.adr_ea      = xu.adr_ptr - 16'h0001;
        xu.adr_wr      = 1'b1;
      end
      AM_DISP: begin
        // the first pointer has no displaced form: plain access instead
        if (xu.adr_disp_ok) begin
          xu.adr_ea = xu.adr_ptr + {10'h000, xu.adr_disp};
        end
      end
    endcase
  end
endmodule : dmbo_addr
`default_nettype wire

// [dmbo_core.sv]
`include "dmbo_defines.svh"
`default_nettype none
module dmbo_core #(
  parameter int PC_W  = 16,
  parameter int IO_AW = 6
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST_N,
  input  wire logic                  OP_VALID,
  input  wire dmbo_pkg::dmbo_op_t    OP_CODE,
  input  wire dmbo_pkg::dmbo_amode_t OP_AMODE,
  input  wire dmbo_pkg::dmbo_sop_t   OP_SHIFT_KIND,
  input  wire logic [1:0]            OP_PTR,
  input  wire logic [4:0]            OP_DST,
  input  wire logic [4:0]            OP_SRC,
  input  wire logic [5:0]            OP_DISP,
  input  wire logic [15:0]           OP_ADDR,
  input  wire logic [2:0]            OP_BIT,
  input  wire logic [6:0]            OP_OFS,
  output logic                       OP_READY,
  output logic [15:0]                DM_ADDR,
  output logic                       DM_RE,
  output logic                       DM_WE,
  output logic [7:0]                 DM_WDATA,
  input  wire logic [7:0]            DM_RDATA,
  output logic [14:0]                PM_ADDR,
  output logic                       PM_RE,
  output logic                       PM_WE,
  output logic [15:0]                PM_WDATA,
  input  wire logic [15:0]           PM_RDATA,
  output logic [IO_AW-1:0]           IO_ADDR,
  output logic                       IO_WE,
  output logic [7:0]                 IO_WMASK,
  output logic [7:0]                 IO_WDATA,
  output logic [PC_W-1:0]            PC_OUT,
  output logic [15:0]                STACK_PTR,
  output logic [7:0]                 STATUS_FLAGS,
  input  wire logic [4:0]            DBG_SEL,
  output logic [7:0]                 DBG_DATA
);
  import dmbo_pkg::*;

  dmbo_xu_if xu ();
  dmbo_shift u_shift (.xu(xu.shf));
  dmbo_addr  u_addr  (.xu(xu.adr));

  dmbo_state_t      state_r,    state_nxt;
  logic [1:0]       cnt_r,      cnt_nxt;
  logic             ready_r,    ready_nxt;
  dmbo_op_t         op_r,       op_nxt;
  logic [4:0]       rd_r,       rd_nxt;
  logic             zodd_r,     zodd_nxt;
  logic [1:0]       psel_r,     psel_nxt;
  logic [7:0]       flags_r,    flags_nxt;
  logic [PC_W-1:0]  pc_r,       pc_nxt;
  logic [15:0]      sp_r,       sp_nxt;
  logic [7:0]       regs_r   [32];
  logic [7:0]       regs_nxt [32];
  logic [15:0]      dm_addr_r,  dm_addr_nxt;
  logic             dm_re_r,    dm_re_nxt;
  logic             dm_we_r,    dm_we_nxt;
  logic [7:0]       dm_wdata_r, dm_wdata_nxt;
  logic [14:0]      pm_addr_r,  pm_addr_nxt;
  logic             pm_re_r,    pm_re_nxt;
  logic             pm_we_r,    pm_we_nxt;
  logic [15:0]      pm_wdata_r, pm_wdata_nxt;
  logic [IO_AW-1:0] io_addr_r,  io_addr_nxt;
  logic             io_we_r,    io_we_nxt;
  logic [7:0]       io_mask_r,  io_mask_nxt;
  logic [7:0]       io_wdata_r, io_wdata_nxt;
  logic [7:0]       dbg_r,      dbg_nxt;

  logic             acc;
  logic             pm_op;
  logic [3:0]       ptr_pair;
  logic [15:0]      ptr_val;
  logic [15:0]      held_ptr;
  logic [7:0]       src_val;
  logic [7:0]       dst_val;
  logic [PC_W-1:0]  ofs_ext;

  assign acc      = OP_VALID && (state_r == ST_IDLE);
  assign pm_op    = (OP_CODE == OP_PROGRAM_MEMORY_LOAD) ||
                    (OP_CODE == OP_PROGRAM_MEMORY_STORE);
  // program-memory access always goes through the third pointer
  assign ptr_pair = pm_op ? `DMBO_PAIR_Z : `DMBO_PAIR_PTR + {2'b00, OP_PTR};
  assign ptr_val  = {regs_r[{ptr_pair, 1'b1}], regs_r[{ptr_pair, 1'b0}]};
  assign held_ptr = {regs_r[{`DMBO_PAIR_PTR + {2'b00, psel_r}, 1'b1}],
                     regs_r[{`DMBO_PAIR_PTR + {2'b00, psel_r}, 1'b0}]};
  assign src_val  = regs_r[OP_SRC];
  assign dst_val  = regs_r[OP_DST];
  assign ofs_ext  = {{(PC_W-7){OP_OFS[6]}}, OP_OFS};

  assign xu.shf_sel     = OP_SHIFT_KIND;
  assign xu.shf_a       = dst_val;
  assign xu.shf_fin     = flags_r;
  assign xu.adr_ptr     = ptr_val;
  assign xu.adr_disp    = OP_DISP;
  assign xu.adr_disp_ok = (OP_PTR != 2'd0);
  assign xu.adr_mode    =
    (OP_CODE == OP_PROGRAM_MEMORY_STORE) ? AM_PLAIN :
    (OP_CODE == OP_PROGRAM_MEMORY_LOAD && OP_AMODE != AM_POSTINC) ?
    AM_PLAIN : OP_AMODE;

  always_comb begin
    logic [1:0] mc;
    mc           = 2'd0;
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    ready_nxt    = ready_r;
    op_nxt       = op_r;
    rd_nxt       = rd_r;
    zodd_nxt     = zodd_r;
    psel_nxt     = psel_r;
    flags_nxt    = flags_r;
    pc_nxt       = pc_r;
    sp_nxt       = sp_r;
    regs_nxt     = regs_r;
    dm_addr_nxt  = dm_addr_r;
    dm_re_nxt    = dm_re_r;
    dm_we_nxt    = dm_we_r;
    dm_wdata_nxt = dm_wdata_r;
    pm_addr_nxt  = pm_addr_r;
    pm_re_nxt    = pm_re_r;
    pm_we_nxt    = pm_we_r;
    pm_wdata_nxt = pm_wdata_r;
    io_addr_nxt  = io_addr_r;
    io_we_nxt    = io_we_r;
    io_mask_nxt  = io_mask_r;
    io_wdata_nxt = io_wdata_r;
    dbg_nxt      = regs_r[DBG_SEL];
    unique case (state_r)
      ST_IDLE: begin
        if (OP_VALID) begin
          op_nxt   = OP_CODE;
          rd_nxt   = OP_DST;
          psel_nxt = OP_PTR;
          pc_nxt   = pc_r + PC_W'(1);
          unique case (OP_CODE)
            OP_NOP: begin
            end
            OP_INDIRECT_LOAD, OP_INDIRECT_STORE: begin
              dm_addr_nxt  = xu.adr_ea;
              dm_re_nxt    = (OP_CODE == OP_INDIRECT_LOAD);
              dm_we_nxt    = (OP_CODE == OP_INDIRECT_STORE);
              dm_wdata_nxt = src_val;
              if (xu.adr_wr) begin
                regs_nxt[{ptr_pair, 1'b0}] = xu.adr_ptr_nxt[7:0];
                regs_nxt[{ptr_pair, 1'b1}] = xu.adr_ptr_nxt[15:8];
              end
              mc = `DMBO_CYC_MEM;
            end
            OP_DIRECT_LOAD, OP_DIRECT_STORE: begin
              dm_addr_nxt  = OP_ADDR;
              dm_re_nxt    = (OP_CODE == OP_DIRECT_LOAD);
              dm_we_nxt    = (OP_CODE == OP_DIRECT_STORE);
              dm_wdata_nxt = src_val;
              pc_nxt       = pc_r + PC_W'(`DMBO_DIRECT_WORDS);
              mc           = `DMBO_CYC_MEM;
            end
            OP_REGISTER_MOVE: regs_nxt[OP_DST] = src_val;
            OP_REGISTER_PAIR_COPY: begin
              regs_nxt[{OP_DST[4:1], 1'b0}] = regs_r[{OP_SRC[4:1], 1'b0}];
              regs_nxt[{OP_DST[4:1], 1'b1}] = regs_r[{OP_SRC[4:1], 1'b1}];
            end
            OP_PROGRAM_MEMORY_LOAD: begin
              pm_addr_nxt = ptr_val[15:1];
              zodd_nxt    = ptr_val[0];
              pm_re_nxt   = 1'b1;
              if (xu.adr_wr) begin
                regs_nxt[{ptr_pair, 1'b0}] = xu.adr_ptr_nxt[7:0];
                regs_nxt[{ptr_pair, 1'b1}] = xu.adr_ptr_nxt[15:8];
              end
              mc = `DMBO_CYC_LPM;
            end
            OP_PROGRAM_MEMORY_STORE: begin
              pm_addr_nxt  = ptr_val[15:1];
              pm_we_nxt    = 1'b1;
              pm_wdata_nxt = {regs_r[{`DMBO_PAIR_R0, 1'b1}],
                              regs_r[{`DMBO_PAIR_R0, 1'b0}]};
              mc           = `DMBO_CYC_SPM;
            end
            OP_PUSH: begin
              dm_addr_nxt  = sp_r;
              dm_we_nxt    = 1'b1;
              dm_wdata_nxt = src_val;
              sp_nxt       = sp_r - 16'h0001;
              mc           = `DMBO_CYC_MEM;
            end
            OP_POP: begin
              dm_addr_nxt = sp_r + 16'h0001;
              dm_re_nxt   = 1'b1;
              sp_nxt      = sp_r + 16'h0001;
              mc          = `DMBO_CYC_MEM;
            end
            OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
              io_addr_nxt  = OP_ADDR[IO_AW-1:0];
              io_we_nxt    = 1'b1;
              io_mask_nxt  = 8'h01 << OP_BIT;
              io_wdata_nxt = (OP_CODE == OP_IO_BIT_SET) ? 8'hFF : 8'h00;
              mc           = `DMBO_CYC_MEM;
            end
            OP_SHIFT: begin
              regs_nxt[OP_DST] = xu.shf_res;
              flags_nxt        = xu.shf_fout;
            end
            OP_FLAG_SET:       flags_nxt[OP_BIT] = 1'b1;
            OP_FLAG_CLEAR:     flags_nxt[OP_BIT] = 1'b0;
            OP_GLOBAL_IRQ_ON:  flags_nxt[`DMBO_FLG_I] = 1'b1;
            OP_GLOBAL_IRQ_OFF: flags_nxt[`DMBO_FLG_I] = 1'b0;
            OP_BIT_TO_TRANSFER_FLAG:
              flags_nxt[`DMBO_FLG_T] = src_val[OP_BIT];
            OP_TRANSFER_FLAG_TO_BIT:
              regs_nxt[OP_DST][OP_BIT] = flags_r[`DMBO_FLG_T];
            OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF: begin
              if (flags_r[`DMBO_FLG_I] == (OP_CODE == OP_BRANCH_IRQ_ON)) begin
                pc_nxt = pc_r + ofs_ext + PC_W'(1);
                mc     = `DMBO_CYC_TAKEN;
              end
            end
          endcase
          if (mc != 2'd0) begin
            state_nxt = ST_EXEC;
            ready_nxt = 1'b0;
            cnt_nxt   = mc - 2'd2;
          end
        end
      end
      ST_EXEC: begin
        if (cnt_r != 2'd0) begin
          cnt_nxt = cnt_r - 2'd1;
        end else begin
          // memory data is sampled in the last cycle of the access
          if (op_r == OP_INDIRECT_LOAD || op_r == OP_DIRECT_LOAD ||
              op_r == OP_POP) begin
            regs_nxt[rd_r] = DM_RDATA;
          end
          if (op_r == OP_PROGRAM_MEMORY_LOAD) begin
            regs_nxt[rd_r] = zodd_r ? PM_RDATA[15:8] : PM_RDATA[7:0];
          end
          dm_re_nxt = 1'b0;
          dm_we_nxt = 1'b0;
          pm_re_nxt = 1'b0;
          pm_we_nxt = 1'b0;
          io_we_nxt = 1'b0;
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_r    <= ST_IDLE;
      cnt_r      <= 2'd0;
      ready_r    <= 1'b1;
      op_r       <= OP_NOP;
      rd_r       <= 5'h00;
      zodd_r     <= 1'b0;
      psel_r     <= 2'd0;
      flags_r    <= `DMBO_FLAGS_RST;
      pc_r       <= '0;
      sp_r       <= `DMBO_SP_RST;
      dm_addr_r  <= 16'h0000;
      dm_re_r    <= 1'b0;
      dm_we_r    <= 1'b0;
      dm_wdata_r <= 8'h00;
      pm_addr_r  <= 15'h0000;
      pm_re_r    <= 1'b0;
      pm_we_r    <= 1'b0;
      pm_wdata_r <= 16'h0000;
      io_addr_r  <= '0;
      io_we_r    <= 1'b0;
      io_mask_r  <= 8'h00;
      io_wdata_r <= 8'h00;
      dbg_r      <= 8'h00;
      for (int i = 0; i < 32; i++) begin
        regs_r[i] <= 8'h00;
      end
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      ready_r    <= ready_nxt;
      op_r       <= op_nxt;
      rd_r       <= rd_nxt;
      zodd_r     <= zodd_nxt;
      psel_r     <= psel_nxt;
      flags_r    <= flags_nxt;
      pc_r       <= pc_nxt;
      sp_r       <= sp_nxt;
      dm_addr_r  <= dm_addr_nxt;
      dm_re_r    <= dm_re_nxt;
      dm_we_r    <= dm_we_nxt;
      dm_wdata_r <= dm_wdata_nxt;
      pm_addr_r  <= pm_addr_nxt;
      pm_re_r    <= pm_re_nxt;
      pm_we_r    <= pm_we_nxt;
      pm_wdata_r <= pm_wdata_nxt;
      io_addr_r  <= io_addr_nxt;
      io_we_r    <= io_we_nxt;
      io_mask_r  <= io_mask_nxt;
      io_wdata_r <= io_wdata_nxt;
      dbg_r      <= dbg_nxt;
      regs_r     <= regs_nxt;
    end
  end

  assign OP_READY     = ready_r;
  assign DM_ADDR      = dm_addr_r;
  assign DM_RE        = dm_re_r;
  assign DM_WE        = dm_we_r;
  assign DM_WDATA     = dm_wdata_r;
  assign PM_ADDR      = pm_addr_r;
  assign PM_RE        = pm_re_r;
  assign PM_WE        = pm_we_r;
  assign PM_WDATA     = pm_wdata_r;
  assign IO_ADDR      = io_addr_r;
  assign IO_WE        = io_we_r;
  assign IO_WMASK     = io_mask_r;
  assign IO_WDATA     = io_wdata_r;
  assign PC_OUT       = pc_r;
  assign STACK_PTR    = sp_r;
  assign STATUS_FLAGS = flags_r;
  assign DBG_DATA     = dbg_r;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence s_two_cycle;
    !OP_READY ##1 OP_READY;
  endsequence
  sequence s_three_cycle;
    !OP_READY [*2] ##1 OP_READY;
  endsequence

  AST_POSTINC_LOAD: assert property (
    acc && OP_CODE == OP_INDIRECT_LOAD && OP_AMODE == AM_POSTINC |=>
    DM_RE && DM_ADDR == $past(ptr_val) &&
    held_ptr == $past(ptr_val) + 16'h0001 ##0 s_two_cycle)
    else $error("post-increment load address or pointer wrong");
  AST_PREDEC_LOAD: assert property (
    acc && OP_CODE == OP_INDIRECT_LOAD && OP_AMODE == AM_PREDEC |=>
    DM_ADDR == $past(ptr_val) - 16'h0001 && held_ptr == DM_ADDR)
    else $error("pre-decrement load address or pointer wrong");
  AST_DISP_LOAD: assert property (
    acc && OP_CODE == OP_INDIRECT_LOAD && OP_AMODE == AM_DISP &&
    OP_PTR != 2'd0 |=> DM_ADDR == $past(ptr_val) + {10'h000, $past(OP_DISP)}
    && held_ptr == $past(ptr_val))
    else $error("displaced load address or pointer wrong");
  AST_STORE_DATA: assert property (
    acc && OP_CODE == OP_INDIRECT_STORE |=>
    DM_WE && DM_WDATA == $past(src_val) ##1 !DM_WE && OP_READY)
    else $error("indirect store data or timing wrong");
  AST_DIRECT_ACCESS: assert property (
    acc && (OP_CODE == OP_DIRECT_LOAD || OP_CODE == OP_DIRECT_STORE) |=>
    DM_ADDR == $past(OP_ADDR) && STATUS_FLAGS == $past(STATUS_FLAGS)
    ##0 s_two_cycle)
    else $error("direct access address or timing wrong");
  AST_MOVE_ONE_CYCLE: assert property (
    acc && OP_CODE == OP_REGISTER_MOVE |=>
    OP_READY && STATUS_FLAGS == $past(STATUS_FLAGS))
    else $error("register move stalled or changed flags");
  AST_PM_LOAD_TIME: assert property (
    acc && OP_CODE == OP_PROGRAM_MEMORY_LOAD |=> PM_RE ##0 s_three_cycle)
    else $error("program-memory load not three cycles");
  AST_PM_STORE_WORD: assert property (
    acc && OP_CODE == OP_PROGRAM_MEMORY_STORE |=>
    PM_WE && PM_WDATA == $past({regs_r[1], regs_r[0]}))
    else $error("program-memory store word wrong");
  AST_PUSH_STACK: assert property (
    acc && OP_CODE == OP_PUSH |=> DM_WE && DM_ADDR == $past(STACK_PTR) &&
    STACK_PTR == $past(STACK_PTR) - 16'h0001 ##0 s_two_cycle)
    else $error("push address or stack pointer wrong");
  AST_IO_BIT_MASK: assert property (
    acc && OP_CODE == OP_IO_BIT_SET |=>
    IO_WE && IO_WMASK == 8'h01 << $past(OP_BIT) && IO_WDATA == 8'hFF)
    else $error("I/O bit set mask wrong");
  AST_SWAP_FLAGS: assert property (
    acc && OP_CODE == OP_SHIFT && OP_SHIFT_KIND == SH_NIBBLE_SWAP |=>
    STATUS_FLAGS == $past(STATUS_FLAGS) &&
    regs_r[$past(OP_DST)] == {$past(dst_val[3:0]), $past(dst_val[7:4])})
    else $error("nibble swap result or flags wrong");
  AST_BRANCH_TAKEN: assert property (
    acc && OP_CODE == OP_BRANCH_IRQ_ON && STATUS_FLAGS[7] |=>
    PC_OUT == $past(PC_OUT) + $past(ofs_ext) + PC_W'(1) ##0 s_two_cycle)
    else $error("taken branch target or timing wrong");
  AST_BRANCH_UNTAKEN: assert property (
    acc && OP_CODE == OP_BRANCH_IRQ_OFF && STATUS_FLAGS[7] |=>
    OP_READY && PC_OUT == $past(PC_OUT) + PC_W'(1))
    else $error("untaken branch stalled");
endmodule : dmbo_core
`default_nettype wire

// [dmbo_core_tb.sv]
`default_nettype none
module dmbo_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dmbo_pkg::*;
  logic CLK_SYS = 1'b0, RST_N = 1'b0, OP_VALID = 1'b0;
  dmbo_op_t OP_CODE = OP_NOP;
  dmbo_amode_t OP_AMODE = AM_PLAIN;
  dmbo_sop_t OP_SHIFT_KIND = SH_LOGICAL_LEFT_SHIFT;
  logic [1:0] OP_PTR = 2'h0;
  logic [4:0] OP_DST = 5'h00, OP_SRC = 5'h00, DBG_SEL = 5'h00;
  logic [15:0] OP_ADDR = 16'h0000;
  logic [2:0] OP_BIT = 3'h0;
  logic OP_READY, DM_RE, DM_WE, PM_RE, IO_WE, PM_WE;
  logic [7:0] DM_WDATA, DM_RDATA, IO_WMASK, IO_WDATA, STATUS_FLAGS;
  logic [7:0] DBG_DATA, f, io_m = 8'h00, io_d = 8'h00;
  logic [15:0] DM_ADDR, PM_RDATA, PC_OUT, STACK_PTR, pc0, PM_WDATA;
  logic [15:0] pm_w = 16'h0000;
  logic [14:0] PM_ADDR;
  logic [5:0] IO_ADDR, OP_DISP = 6'h00, io_a = 6'h00;
  logic [6:0] OP_OFS = 7'h05;
  int err_total = 0, cmp_count = 0, cyc = 0;
  always #2 CLK_SYS = ~CLK_SYS;
  dmbo_core u_dmbo_core (.CLK_SYS, .RST_N, .OP_VALID, .OP_CODE, .OP_AMODE,
    .OP_SHIFT_KIND, .OP_PTR, .OP_DST, .OP_SRC, .OP_DISP, .OP_ADDR,
    .OP_BIT, .OP_OFS, .OP_READY, .DM_ADDR, .DM_RE, .DM_WE, .DM_WDATA,
    .DM_RDATA, .PM_ADDR, .PM_RE, .PM_WE, .PM_WDATA, .PM_RDATA, .IO_ADDR,
    .IO_WE, .IO_WMASK, .IO_WDATA, .PC_OUT, .STACK_PTR, .STATUS_FLAGS,
    .DBG_SEL, .DBG_DATA);
  dmbo_mem_model u_dmbo_mem_model (.CLK_SYS, .DM_ADDR, .DM_RE, .DM_WE,
    .DM_WDATA, .DM_RDATA, .PM_ADDR, .PM_RE, .PM_RDATA);
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  always @(posedge CLK_SYS) begin
    cyc <= cyc + 1;
    if (IO_WE) begin
      io_m <= IO_WMASK;
      io_d <= IO_WDATA & IO_WMASK;
      io_a <= IO_ADDR;
    end
    if (PM_WE) pm_w <= PM_WDATA;
    if (cyc == 2000) begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // offer one operation, then count cycles until ready returns
  task automatic op(input dmbo_op_t c, input logic [4:0] d,
    input logic [4:0] s, input logic [15:0] a, input int n,
    input dmbo_amode_t m = AM_PLAIN);
    int k;
    @(negedge CLK_SYS);
    OP_VALID = 1'b1;
    OP_CODE = c;
    OP_AMODE = m;
    OP_DST = d;
    OP_SRC = s;
    OP_ADDR = a;
    @(negedge CLK_SYS);
    OP_VALID = 1'b0;
    k = 1;
    while (OP_READY !== 1'b1) begin
      @(negedge CLK_SYS);
      k++;
    end
    chk(16'(n), 16'(k));
  endtask : op
  task automatic rd(input logic [4:0] r, input logic [7:0] e);
    @(negedge CLK_SYS);
    DBG_SEL = r;
    @(negedge CLK_SYS);
    chk({8'h00, e}, {8'h00, DBG_DATA});
  endtask : rd
  task automatic sh(input dmbo_sop_t k, input logic [4:0] r,
    input logic [7:0] e, input logic c);
    OP_SHIFT_KIND = k;
    op(OP_SHIFT, r, r, 16'h0000, 1);
    rd(r, e);
    chk({15'h0000, c}, {15'h0000, STATUS_FLAGS[0]});
  endtask : sh
  initial begin
    repeat (10) @(negedge CLK_SYS);
    RST_N = 1'b1;
    op(OP_DIRECT_LOAD, 5'h1A, 5'h00, 16'h0010, 2);
    rd(5'h1A, 8'h13);
    op(OP_DIRECT_LOAD, 5'h1B, 5'h00, 16'h0020, 2);
    op(OP_INDIRECT_LOAD, 5'h01, 5'h00, 16'h0000, 2, AM_POSTINC);
    rd(5'h01, 8'h16);
    rd(5'h1A, 8'h14);
    op(OP_INDIRECT_LOAD, 5'h02, 5'h00, 16'h0000, 2, AM_PREDEC);
    rd(5'h02, 8'h16);
    rd(5'h1A, 8'h13);
    op(OP_DIRECT_STORE, 5'h00, 5'h1A, 16'h0040, 2);
    op(OP_DIRECT_LOAD, 5'h03, 5'h00, 16'h0040, 2);
    rd(5'h03, 8'h13);
    op(OP_REGISTER_MOVE, 5'h06, 5'h01, 16'h0000, 1);
    rd(5'h06, 8'h16);
    op(OP_INDIRECT_STORE, 5'h00, 5'h03, 16'h0000, 2, AM_POSTINC);
    op(OP_DIRECT_LOAD, 5'h04, 5'h00, 16'h0013, 2);
    rd(5'h04, 8'h13);
    rd(5'h1A, 8'h14);
    op(OP_PUSH, 5'h00, 5'h03, 16'h0000, 2);
    op(OP_POP, 5'h05, 5'h00, 16'h0000, 2);
    rd(5'h05, 8'h13);
    chk(16'h0000, STACK_PTR);
    sh(SH_LOGICAL_LEFT_SHIFT, 5'h02, 8'h2C, 1'b0);
    sh(SH_LOGICAL_RIGHT_SHIFT, 5'h01, 8'h0B, 1'b0);
    sh(SH_CARRY_RIGHT_ROTATE, 5'h03, 8'h09, 1'b1);
    sh(SH_CARRY_LEFT_ROTATE, 5'h03, 8'h13, 1'b0);
    f = STATUS_FLAGS;
    sh(SH_NIBBLE_SWAP, 5'h02, 8'hC2, 1'b0);
    chk({8'h00, f}, {8'h00, STATUS_FLAGS});
    sh(SH_ARITHMETIC_RIGHT_SHIFT, 5'h02, 8'hE1, 1'b0);
    chk(16'h0001, {15'h0000, STATUS_FLAGS[2]});
    OP_PTR = 2'h2;
    op(OP_PROGRAM_MEMORY_LOAD, 5'h07, 5'h00, 16'h0000, 3);
    rd(5'h07, 8'h40);
    OP_DISP = 6'h21;
    op(OP_INDIRECT_LOAD, 5'h0A, 5'h00, 16'h0000, 2, AM_DISP);
    rd(5'h0A, 8'h24);
    OP_DISP = 6'h22;
    op(OP_INDIRECT_STORE, 5'h00, 5'h0A, 16'h0000, 2, AM_DISP);
    op(OP_DIRECT_LOAD, 5'h0B, 5'h00, 16'h0022, 2);
    rd(5'h0B, 8'h24);
    op(OP_REGISTER_PAIR_COPY, 5'h08, 5'h02, 16'h0000, 1);
    rd(5'h08, 8'hE1);
    rd(5'h09, 8'h13);
    op(OP_REGISTER_MOVE, 5'h00, 5'h02, 16'h0000, 1);
    op(OP_PROGRAM_MEMORY_STORE, 5'h00, 5'h00, 16'h0000, 2);
    chk(16'h0BE1, pm_w);
    OP_BIT = 3'h3;
    op(OP_IO_BIT_SET, 5'h00, 5'h00, 16'h0012, 2);
    chk(16'h0808, {io_m, io_d});
    chk(16'h0012, {10'h000, io_a});
    op(OP_IO_BIT_CLEAR, 5'h00, 5'h00, 16'h0012, 2);
    chk(16'h0800, {io_m, io_d});
    for (int b = 0; b < 7; b++) begin
      OP_BIT = 3'(b);
      f = STATUS_FLAGS;
      op(OP_FLAG_SET, 5'h00, 5'h00, 16'h0000, 1);
      chk(16'(f | (8'h01 << b)), 16'(STATUS_FLAGS));
      op(OP_FLAG_CLEAR, 5'h00, 5'h00, 16'h0000, 1);
      chk(16'(f & ~(8'h01 << b)), 16'(STATUS_FLAGS));
    end
    OP_BIT = 3'h0;
    op(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h02, 16'h0000, 1);
    chk(16'h0040, 16'(STATUS_FLAGS));
    op(OP_TRANSFER_FLAG_TO_BIT, 5'h07, 5'h00, 16'h0000, 1);
    rd(5'h07, 8'h41);
    f = STATUS_FLAGS;
    op(OP_GLOBAL_IRQ_ON, 5'h00, 5'h00, 16'h0000, 1);
    chk(16'(f | 8'h80), 16'(STATUS_FLAGS));
    pc0 = PC_OUT;
    op(OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 16'h0000, 2);
    chk(pc0 + 16'h0006, PC_OUT);
    pc0 = PC_OUT;
    op(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 16'h0000, 1);
    chk(pc0 + 16'h0001, PC_OUT);
    op(OP_GLOBAL_IRQ_OFF, 5'h00, 5'h00, 16'h0000, 1);
    chk(16'(f & 8'h7F), 16'(STATUS_FLAGS));
    pc0 = PC_OUT;
    op(OP_BRANCH_IRQ_ON, 5'h00, 5'h00, 16'h0000, 1);
    chk(pc0 + 16'h0001, PC_OUT);
    OP_OFS = 7'h7D;
    pc0 = PC_OUT;
    op(OP_BRANCH_IRQ_OFF, 5'h00, 5'h00, 16'h0000, 2);
    chk(pc0 - 16'h0002, PC_OUT);
    final_report();
  end
endmodule : dmbo_core_tb
`default_nettype wire

// [dmbo_defines.svh]
`ifndef DMBO_DEFINES_SVH
`define DMBO_DEFINES_SVH
`define DMBO_FLG_C 3'd0
`define DMBO_FLG_Z 3'd1
`define DMBO_FLG_N 3'd2
`define DMBO_FLG_V 3'd3
`define DMBO_FLG_S 3'd4
`define DMBO_FLG_H 3'd5
`define DMBO_FLG_T 3'd6
`define DMBO_FLG_I 3'd7
`define DMBO_FLAGS_RST 8'h00
`define DMBO_SP_RST 16'h0000
`define DMBO_PAIR_R0 4'h0
`define DMBO_PAIR_PTR 4'hD
`define DMBO_PAIR_Z 4'hF
`define DMBO_CYC_MEM 2'd2
`define DMBO_CYC_LPM 2'd3
`define DMBO_CYC_SPM 2'd2
`define DMBO_CYC_TAKEN 2'd2
`define DMBO_DIRECT_WORDS 2'd2
`endif

// [dmbo_mem_model.sv]
`default_nettype none
module dmbo_mem_model (
  input  wire logic        CLK_SYS,
  input  wire logic [15:0] DM_ADDR,
  input  wire logic        DM_RE,
  input  wire logic        DM_WE,
  input  wire logic [7:0]  DM_WDATA,
  output logic      [7:0]  DM_RDATA,
  input  wire logic [14:0] PM_ADDR,
  input  wire logic        PM_RE,
  output logic      [15:0] PM_RDATA
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0]  mem_r [256];
  logic [7:0]  last_r = 8'h00;
  logic [15:0] pw;
  initial for (int i = 0; i < 256; i++) mem_r[i] = 8'(i + 3);
  always @(posedge CLK_SYS) begin
    if (DM_WE) mem_r[DM_ADDR[7:0]] <= DM_WDATA;
    if (DM_RE) last_r <= mem_r[DM_ADDR[7:0]];
  end
  // idle buses show inverted data so a late sample cannot pass
  assign DM_RDATA = DM_RE ? mem_r[DM_ADDR[7:0]] : ~last_r;
  assign pw = {8'hA5, PM_ADDR[7:0] + 8'h40};
  assign PM_RDATA = PM_RE ? pw : ~pw;
endmodule : dmbo_mem_model
`default_nettype wire

// [dmbo_pkg.sv]
`default_nettype none
package dmbo_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_INDIRECT_LOAD, OP_INDIRECT_STORE, OP_DIRECT_LOAD,
    OP_DIRECT_STORE, OP_REGISTER_MOVE, OP_REGISTER_PAIR_COPY,
    OP_PROGRAM_MEMORY_LOAD, OP_PROGRAM_MEMORY_STORE, OP_PUSH, OP_POP,
    OP_IO_BIT_SET, OP_IO_BIT_CLEAR, OP_SHIFT, OP_FLAG_SET, OP_FLAG_CLEAR,
    OP_GLOBAL_IRQ_ON, OP_GLOBAL_IRQ_OFF, OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT, OP_BRANCH_IRQ_ON, OP_BRANCH_IRQ_OFF
  } dmbo_op_t;
  typedef enum logic [1:0] {AM_PLAIN, AM_POSTINC, AM_PREDEC, AM_DISP}
    dmbo_amode_t;
  typedef enum logic [2:0] {
    SH_LOGICAL_LEFT_SHIFT, SH_LOGICAL_RIGHT_SHIFT, SH_CARRY_LEFT_ROTATE,
    SH_CARRY_RIGHT_ROTATE, SH_ARITHMETIC_RIGHT_SHIFT, SH_NIBBLE_SWAP
  } dmbo_sop_t;
  typedef enum logic {ST_IDLE, ST_EXEC} dmbo_state_t;
endpackage : dmbo_pkg
`default_nettype wire

// [dmbo_shift.sv]
`include "dmbo_defines.svh"
`default_nettype none
module dmbo_shift (
  dmbo_xu_if.shf xu
);
  import dmbo_pkg::*;
  always_comb begin
    logic [7:0] r;
    logic       c;
    logic [7:0] f;
    r = xu.shf_a;
    c = xu.shf_fin[`DMBO_FLG_C];
    f = xu.shf_fin;
    unique case (xu.shf_sel)
      SH_LOGICAL_LEFT_SHIFT:     {c, r} = {xu.shf_a, 1'b0};
      SH_LOGICAL_RIGHT_SHIFT:    {r, c} = {1'b0, xu.shf_a};
      SH_CARRY_LEFT_ROTATE:      {c, r} = {xu.shf_a, f[`DMBO_FLG_C]};
      SH_CARRY_RIGHT_ROTATE:     {r, c} = {f[`DMBO_FLG_C], xu.shf_a};
      SH_ARITHMETIC_RIGHT_SHIFT: {r, c} = {xu.shf_a[7], xu.shf_a};
      SH_NIBBLE_SWAP:            r = {xu.shf_a[3:0], xu.shf_a[7:4]};
    endcase
    if (xu.shf_sel != SH_NIBBLE_SWAP) begin
      f[`DMBO_FLG_Z] = (r == 8'h00);
      f[`DMBO_FLG_C] = c;
      f[`DMBO_FLG_N] = r[7];
      f[`DMBO_FLG_V] = r[7] ^ c;
      f[`DMBO_FLG_S] = r[7] ^ r[7] ^ c;
      // half carry follows bit 3 on the left-moving forms
      if (xu.shf_sel == SH_LOGICAL_LEFT_SHIFT ||
          xu.shf_sel == SH_CARRY_LEFT_ROTATE) begin
        f[`DMBO_FLG_H] = xu.shf_a[3];
      end
    end
    xu.shf_res  = r;
    xu.shf_fout = f;
  end
endmodule : dmbo_shift
`default_nettype wire

// [dmbo_xu_if.sv]
`default_nettype none
interface dmbo_xu_if;
  import dmbo_pkg::*;
  dmbo_sop_t   shf_sel;
  logic [7:0]  shf_a;
  logic [7:0]  shf_fin;
  logic [7:0]  shf_res;
  logic [7:0]  shf_fout;
  logic [15:0] adr_ptr;
  dmbo_amode_t adr_mode;
  logic [5:0]  adr_disp;
  logic        adr_disp_ok;
  logic [15:0] adr_ea;
  logic [15:0] adr_ptr_nxt;
  logic        adr_wr;
  modport core (output shf_sel, shf_a, shf_fin, adr_ptr, adr_mode,
                adr_disp, adr_disp_ok,
                input shf_res, shf_fout, adr_ea, adr_ptr_nxt, adr_wr);
  modport shf (input shf_sel, shf_a, shf_fin, output shf_res, shf_fout);
  modport adr (input adr_ptr, adr_mode, adr_disp, adr_disp_ok,
               output adr_ea, adr_ptr_nxt, adr_wr);
endinterface : dmbo_xu_if
`default_nettype wire
